// ---- sse_pkg.sv ----
// shared constants and carrier types of the member enable command block
// assumes a single clock domain and byte-wide request and response streams
`default_nettype none
package sse_pkg;
    localparam int MEMBERS = 8;
    localparam logic [15:0] HANDLE_RSV_LO = 16'h0000;
    localparam logic [15:0] HANDLE_RSV_HI = 16'hffff;
    localparam logic [15:0] HANDLE_RESET = 16'h0001;
    localparam logic [7:0] COUNT_MIN = 8'h01;
    localparam logic [7:0] COUNT_MAX = 8'h08;
    // operational state codes, two low bits kept per member
    localparam logic [7:0] OP_ENABLED = 8'h01;
    localparam logic [7:0] OP_DISABLED = 8'h02;
    localparam logic [7:0] OP_UNAVAIL = 8'h03;
    localparam logic [7:0] EV_ON = 8'h00;
    localparam logic [7:0] EV_OFF = 8'h01;
    localparam logic [7:0] EV_KEEP = 8'hff;
    // result codes
    localparam logic [7:0] RC_SUCCESS = 8'h00;
    localparam logic [7:0] RC_BAD_DATA = 8'h02;
    localparam logic [7:0] RC_BAD_LEN = 8'h03;
    localparam logic [7:0] RC_BAD_HANDLE = 8'h80;
    // register byte offsets
    localparam logic [5:0] REG_HANDLE = 6'h00;
    localparam logic [5:0] REG_DEF_MASK = 6'h04;
    localparam logic [5:0] REG_DEF_LO = 6'h08;
    localparam logic [5:0] REG_DEF_HI = 6'h0c;
    localparam logic [5:0] REG_MEMBER = 6'h10;
    localparam logic [5:0] REG_VAL_LO = 6'h14;
    localparam logic [5:0] REG_VAL_HI = 6'h18;
    localparam logic [5:0] REG_IRQ_ST = 6'h1c;
    localparam logic [5:0] REG_IRQ_CLR = 6'h20;
    localparam logic [5:0] REG_IRQ_EN = 6'h24;
    localparam int IRQ_W = 4;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_HANDLE = 1;
    localparam int IRQ_REFUSED = 2;
    localparam int IRQ_BAD_REQ = 3;

    typedef struct packed {
        logic [7:0] op;
        logic [7:0] ev;
    } sse_record_type;

    typedef struct packed {
        logic [1:0] op;
        logic events;
        logic [7:0] value;
    } sse_member_type;

    typedef struct packed {
        logic read;
        logic write;
        logic [5:0] address;
        logic [31:0] writedata;
    } sse_avs_req_type;
endpackage
`default_nettype wire

// ---- sse_member_store.sv ----
// per-member operational state, event switch and present state value
// assumes apply records were checked for legal codes before the pulse
`timescale 1ns/1ps
`default_nettype none
module sse_member_store (
    input wire logic clk,
    input wire logic nrst,
    input wire logic apply,
    input wire logic [3:0] count,
    input wire sse_pkg::sse_record_type [sse_pkg::MEMBERS-1:0] recs,
    input wire logic [7:0] def_mask,
    input wire logic [7:0][7:0] def_value,
    input wire logic set_valid,
    input wire logic [2:0] set_index,
    input wire logic [7:0] set_value,
    output logic set_refused,
    output logic set_accepted,
    output sse_pkg::sse_member_type [sse_pkg::MEMBERS-1:0] members,
    output logic [7:0] event_pulse
);
    import sse_pkg::*;

    typedef struct packed {
        sse_member_type [MEMBERS-1:0] m;
        logic refused;
        logic accepted;
        logic [7:0] evp;
    } sse_store_type;

    sse_store_type r, n;

    always_comb begin
        n = r;
        n.refused = 1'b0;
        n.accepted = 1'b0;
        n.evp = '0;
        if (set_valid) begin
            // disabled and unavailable members both take no state change
            if (r.m[set_index].op != OP_ENABLED[1:0]) begin
                n.refused = 1'b1;
            end else begin
                n.m[set_index].value = set_value;
                n.accepted = 1'b1;
                n.evp[set_index] = r.m[set_index].events && (r.m[set_index].value != set_value);
            end
        end
        // a command that lands with a state write overrides its value only when it loads a default
        if (apply) begin
            for (int i = 0; i < MEMBERS; i++) begin
                if (i < int'(count)) begin
                    n.m[i].op = recs[i].op[1:0];
                    if (recs[i].op == OP_DISABLED && r.m[i].op != OP_DISABLED[1:0] && def_mask[i]) begin
                        n.m[i].value = def_value[i];
                        n.evp[i] = r.m[i].events && (r.m[i].value != def_value[i]);
                    end
                    if (recs[i].ev == EV_ON) begin
                        n.m[i].events = 1'b1;
                    end else if (recs[i].ev == EV_OFF) begin
                        n.m[i].events = 1'b0;
                    end
                    // keep code leaves the switch alone
                end
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            for (int i = 0; i < MEMBERS; i++) begin
                r.m[i].op <= OP_ENABLED[1:0];
            end
        end else begin
            r <= n;
        end
    end

    assign members = r.m;
    assign set_refused = r.refused;
    assign set_accepted = r.accepted;
    assign event_pulse = r.evp;
endmodule
`default_nettype wire

// ---- sse_csr.sv ----
// avalon-mm register file with sticky interrupt status
// assumes byte addresses and whole 32-bit accesses
`timescale 1ns/1ps
`default_nettype none
module sse_csr (
    input wire logic clk,
    input wire logic nrst,
    input wire sse_pkg::sse_avs_req_type req,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire sse_pkg::sse_member_type [sse_pkg::MEMBERS-1:0] members,
    input wire logic [sse_pkg::IRQ_W-1:0] irq_event,
    output logic [15:0] own_handle,
    output logic [7:0] def_mask,
    output logic [7:0][7:0] def_value,
    output logic irq
);
    import sse_pkg::*;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [15:0] handle;
        logic [7:0] mask;
        logic [7:0][7:0] dval;
        logic [IRQ_W-1:0] st;
        logic [IRQ_W-1:0] en;
    } sse_csr_type;

    sse_csr_type r, n;
    logic [IRQ_W-1:0] clr;
    logic [7:0] evs;
    logic [7:0][7:0] vals;

    always_comb begin
        n = r;
        clr = '0;
        evs = '0;
        vals = '0;
        for (int i = 0; i < MEMBERS; i++) begin
            evs[i] = members[i].events;
            vals[i] = members[i].value;
        end
        // one wait cycle per access keeps read data registered
        n.ack = (req.read || req.write) && !r.ack;
        if (req.read && !r.ack) begin
            unique case (req.address)
                REG_HANDLE: n.rdata = {16'h0000, r.handle};
                REG_DEF_MASK: n.rdata = {24'h000000, r.mask};
                REG_DEF_LO: n.rdata = r.dval[3:0];
                REG_DEF_HI: n.rdata = r.dval[7:4];
                REG_MEMBER: n.rdata = {8'h00, evs, members[7].op, members[6].op, members[5].op,
                    members[4].op, members[3].op, members[2].op, members[1].op, members[0].op};
                REG_VAL_LO: n.rdata = vals[3:0];
                REG_VAL_HI: n.rdata = vals[7:4];
                REG_IRQ_ST: n.rdata = {28'h0000000, r.st};
                REG_IRQ_EN: n.rdata = {28'h0000000, r.en};
                default: n.rdata = 32'h00000000;
            endcase
        end
        if (req.write && r.ack) begin
            unique case (req.address)
                REG_HANDLE: n.handle = req.writedata[15:0];
                REG_DEF_MASK: n.mask = req.writedata[7:0];
                REG_DEF_LO: n.dval[3:0] = req.writedata;
                REG_DEF_HI: n.dval[7:4] = req.writedata;
                REG_IRQ_CLR: clr = req.writedata[IRQ_W-1:0];
                REG_IRQ_EN: n.en = req.writedata[IRQ_W-1:0];
                default: n.en = r.en;
            endcase
        end
        // a new event in the clearing cycle survives
        n.st = (r.st & ~clr) | irq_event;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.handle <= HANDLE_RESET;
        end else begin
            r <= n;
        end
    end

    assign readdata = r.rdata;
    assign waitrequest = (req.read || req.write) && !r.ack;
    assign own_handle = r.handle;
    assign def_mask = r.mask;
    assign def_value = r.dval;
    assign irq = |(r.st & r.en);
endmodule
`default_nettype wire

// ---- sse_enable_cmd.sv ----
// member enable command interpreter, top level
// assumes requests arrive as a byte stream with a last marker per request
//
// Operation
// - each addressed member is switched to the operational state in its record
// - a disabled member refuses every state change
// - a member with a default state returns to it when disabled
// - handle is 16 bits; 0x0000 and 0xffff are reserved and rejected
// - member count runs 0x01 to 0x08, members are offsets 0 to 7
// - one record per member: operational state byte then event switch byte
// - state byte accepts only enabled, disabled (2) and unavailable (3)
// - event switch byte decides event generation for that member
// - event switch codes: events on, events off, keep setting 0xff
// - keep setting code leaves the member's event switch unchanged
// - response is one result code byte; 0x80 for a bad handle
// - unavailable members are treated as ignored and take no state change
`timescale 1ns/1ps
`default_nettype none
module sse_enable_cmd (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_last,
    output logic rx_ready,
    output logic resp_valid,
    output logic [7:0] resp_code,
    input wire logic resp_ready,
    input wire logic set_valid,
    input wire logic [2:0] set_index,
    input wire logic [7:0] set_value,
    output logic set_refused,
    output logic set_accepted,
    output logic [7:0] member_events,
    output logic [7:0] event_pulse,
    output logic irq
);
    import sse_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // types and helpers

    typedef enum logic [2:0] {
        ST_HLO = 3'b000,
        ST_HHI = 3'b001,
        ST_CNT = 3'b011,
        ST_OP = 3'b010,
        ST_EV = 3'b110,
        ST_DRAIN = 3'b111,
        ST_RESP = 3'b101
    } sse_state_type;

    typedef struct packed {
        sse_state_type st;
        logic [15:0] handle;
        logic [3:0] count;
        logic [2:0] idx;
        sse_record_type [MEMBERS-1:0] recs;
        logic [7:0] err;
        logic [7:0] code;
        logic resp;
        logic apply;
        logic [IRQ_W-1:0] ev;
    } sse_cmd_type;

    // the first error of a request is the one reported
    function automatic logic [7:0] keep_first(input logic [7:0] cur, input logic [7:0] nw);
        return (cur == RC_SUCCESS) ? nw : cur;
    endfunction

    function automatic logic bad_handle(input logic [15:0] h, input logic [15:0] own);
        return (h == HANDLE_RSV_LO) || (h == HANDLE_RSV_HI) || (h != own);
    endfunction

    function automatic logic [IRQ_W-1:0] result_events(input logic [7:0] code);
        logic [IRQ_W-1:0] e;
        e = '0;
        e[IRQ_DONE] = 1'b1;
        e[IRQ_HANDLE] = (code == RC_BAD_HANDLE);
        e[IRQ_BAD_REQ] = (code != RC_SUCCESS) && (code != RC_BAD_HANDLE);
        return e;
    endfunction

    sse_cmd_type r, n;
    sse_avs_req_type req;
    sse_member_type [MEMBERS-1:0] members;
    logic [15:0] own_handle;
    logic [7:0] def_mask;
    logic [7:0][7:0] def_value;
    logic refused;
    logic [IRQ_W-1:0] irq_event;
    logic take;
    logic [7:0] fin;

    ////////////////////////////////////////////////////////////////////////////////
    // request parser

    assign take = rx_valid && rx_ready;

    always_comb begin
        n = r;
        n.apply = 1'b0;
        n.ev = '0;
        fin = RC_SUCCESS;
        unique case (r.st)
            ST_HLO: begin
                if (take) begin
                    n.handle[7:0] = rx_data;
                    n.err = RC_SUCCESS;
                    n.st = rx_last ? ST_RESP : ST_HHI;
                    n.code = RC_BAD_LEN;
                end
            end
            ST_HHI: begin
                if (take) begin
                    n.handle[15:8] = rx_data;
                    n.st = rx_last ? ST_RESP : ST_CNT;
                    n.code = RC_BAD_LEN;
                end
            end
            ST_CNT: begin
                if (take) begin
                    n.count = rx_data[3:0];
                    n.idx = '0;
                    if (bad_handle(r.handle, own_handle)) begin
                        n.err = RC_BAD_HANDLE;
                    end else if (rx_data < COUNT_MIN || rx_data > COUNT_MAX) begin
                        n.err = RC_BAD_DATA;
                    end
                    if (rx_last) begin
                        n.st = ST_RESP;
                        n.code = keep_first(n.err, RC_BAD_LEN);
                    end else begin
                        n.st = (n.err != RC_SUCCESS) ? ST_DRAIN : ST_OP;
                    end
                end
            end
            ST_OP: begin
                if (take) begin
                    n.recs[r.idx].op = rx_data;
                    if (rx_data != OP_ENABLED && rx_data != OP_DISABLED && rx_data != OP_UNAVAIL) begin
                        n.err = keep_first(r.err, RC_BAD_DATA);
                    end
                    if (rx_last) begin
                        n.st = ST_RESP;
                        n.code = keep_first(n.err, RC_BAD_LEN);
                    end else begin
                        n.st = ST_EV;
                    end
                end
            end
            ST_EV: begin
                if (take) begin
                    n.recs[r.idx].ev = rx_data;
                    if (rx_data != EV_ON && rx_data != EV_OFF && rx_data != EV_KEEP) begin
                        n.err = keep_first(r.err, RC_BAD_DATA);
                    end
                    if ({1'b0, r.idx} == r.count - 4'h1) begin
                        if (rx_last) begin
                            // all records checked before any member changes
                            fin = n.err;
                            n.apply = (fin == RC_SUCCESS);
                            n.st = ST_RESP;
                            n.code = fin;
                        end else begin
                            n.err = keep_first(n.err, RC_BAD_LEN);
                            n.st = ST_DRAIN;
                        end
                    end else if (rx_last) begin
                        n.st = ST_RESP;
                        n.code = keep_first(n.err, RC_BAD_LEN);
                    end else begin
                        n.idx = r.idx + 3'h1;
                        n.st = ST_OP;
                    end
                end
            end
            ST_DRAIN: begin
                // swallow the rest of a failed request so framing is kept
                if (take && rx_last) begin
                    n.st = ST_RESP;
                    n.code = r.err;
                end
            end
            ST_RESP: begin
                if (resp_ready) begin
                    n.st = ST_HLO;
                end
            end
            default: n.st = ST_HLO;
        endcase
        // response raised on entry, one interrupt event per request
        n.resp = (n.st == ST_RESP);
        if (n.st == ST_RESP && r.st != ST_RESP) begin
            n.ev = result_events(n.code);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
            r.st <= ST_HLO;
        end else begin
            r <= n;
        end
    end

    assign rx_ready = (r.st != ST_RESP);
    assign resp_valid = r.resp;
    assign resp_code = r.code;

    ////////////////////////////////////////////////////////////////////////////////
    // member state

    sse_member_store u_store (
        .clk(clk),
        .nrst(nrst),
        .apply(r.apply),
        .count(r.count),
        .recs(r.recs),
        .def_mask(def_mask),
        .def_value(def_value),
        .set_valid(set_valid),
        .set_index(set_index),
        .set_value(set_value),
        .set_refused(refused),
        .set_accepted(set_accepted),
        .members(members),
        .event_pulse(event_pulse)
    );

    assign set_refused = refused;

    always_comb begin
        for (int i = 0; i < MEMBERS; i++) begin
            member_events[i] = members[i].events;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers and interrupt

    always_comb begin
        req.read = avs_read;
        req.write = avs_write;
        req.address = avs_address;
        req.writedata = avs_writedata;
        irq_event = r.ev;
        irq_event[IRQ_REFUSED] = refused;
    end

    sse_csr u_csr (
        .clk(clk),
        .nrst(nrst),
        .req(req),
        .readdata(avs_readdata),
        .waitrequest(avs_waitrequest),
        .members(members),
        .irq_event(irq_event),
        .own_handle(own_handle),
        .def_mask(def_mask),
        .def_value(def_value),
        .irq(irq)
    );
endmodule
`default_nettype wire

// ---- sse_enable_cmd_assertions.sv ----
// concurrent checks on the block's ports
// assumes one clock domain; bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module sse_enable_cmd_assertions (
    input wire logic clk,
    input wire logic nrst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic rx_valid,
    input wire logic rx_last,
    input wire logic rx_ready,
    input wire logic resp_valid,
    input wire logic [7:0] resp_code,
    input wire logic resp_ready,
    input wire logic set_valid,
    input wire logic set_refused,
    input wire logic set_accepted
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    sequence bus_first;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence last_taken;
        rx_valid && rx_ready && rx_last;
    endsequence
    sequence resp_held;
        resp_valid && !resp_ready;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    chk_one_wait: assert property (bus_first |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    chk_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high without a request");
    chk_resp_follows: assert property (last_taken |=> resp_valid && !rx_ready)
        else $error("no response after last byte");
    chk_resp_cause: assert property ($rose(resp_valid) |-> $past(rx_valid && rx_ready && rx_last))
        else $error("response without request");
    chk_resp_hold: assert property (resp_held |=> resp_valid && $stable(resp_code))
        else $error("response changed before acceptance");
    chk_resp_drop: assert property (resp_valid && resp_ready |=> !resp_valid)
        else $error("response stayed after acceptance");
    chk_rx_open: assert property (!resp_valid |-> rx_ready)
        else $error("stream blocked with no response");
    chk_set_answer: assert property (set_valid |=> set_refused ^ set_accepted)
        else $error("state change not answered once");
    chk_set_quiet: assert property (!set_valid |=> !set_refused && !set_accepted)
        else $error("state change answer without attempt");
    cover property (last_taken ##1 resp_valid && resp_code == 8'h00);
endmodule
`default_nettype wire

// ---- sse_host_model.sv ----
// controller model: streams request bytes and accepts result codes
// assumes the bench calls send one request at a time
`timescale 1ns/1ps
`default_nettype none
module sse_host_model (
    input wire logic clk,
    input wire logic rx_ready,
    input wire logic resp_valid,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic resp_ready
);
    initial {rx_valid, rx_data, rx_last, resp_ready} = '0;
    // handle low, handle high, count, then op/ev pairs
    task automatic send(input logic [7:0] b [$], input int gap);
        for (int i = 0; i < b.size(); i++) begin
            rx_valid <= 1'b1;
            rx_data <= b[i];
            rx_last <= (i == b.size() - 1);
            do @(posedge clk); while (!rx_ready);
            // idle line shows the inverse byte
            if (gap > 0 || i == b.size() - 1) begin
                rx_valid <= 1'b0;
                rx_last <= 1'b0;
                rx_data <= ~b[i];
                repeat (gap) @(posedge clk);
            end
        end
        resp_ready <= 1'b1;
        do @(posedge clk); while (!resp_valid);
        resp_ready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- sse_enable_cmd_test.sv ----
// self-checking bench for the member enable command block
// assumes the host model on the request stream
`timescale 1ns/1ps
`default_nettype none
module sse_enable_cmd_test;
    import sse_pkg::*;
    logic clk, nrst, avs_read, avs_write, rx_valid, rx_last, rx_ready, resp_valid, resp_ready;
    logic avs_waitrequest, set_valid, set_refused, set_accepted, irq;
    logic [5:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [7:0] rx_data, resp_code, set_value, member_events, event_pulse, dmask, exp_ev;
    logic [2:0] set_index;
    logic [7:0][7:0] rq_op, rq_ev, exp_val, dval;
    logic [7:0][1:0] exp_op;
    logic [15:0] own;
    logic [7:0] resp_q [$];
    logic [8:0] set_q [$];
    int num_errors = 0;
    int n_checks = 0;
    integer seed = 32'ha2ab7ba0;
    sse_enable_cmd dut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
        .rx_ready(rx_ready), .resp_valid(resp_valid), .resp_code(resp_code), .resp_ready(resp_ready),
        .set_valid(set_valid), .set_index(set_index), .set_value(set_value), .set_refused(set_refused),
        .set_accepted(set_accepted), .member_events(member_events), .event_pulse(event_pulse), .irq(irq));
    sse_host_model u_host (.clk(clk), .rx_ready(rx_ready), .resp_valid(resp_valid), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_last(rx_last), .resp_ready(resp_ready));
    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk); while (avs_waitrequest);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic check_members();
        rd_chk(REG_MEMBER, {8'h00, exp_ev, exp_op});
        rd_chk(REG_VAL_LO, exp_val[3:0]);
        rd_chk(REG_VAL_HI, exp_val[7:4]);
        check({24'h0, member_events}, {24'h0, exp_ev});
    endtask
    // members move only on success
    task automatic req(input logic [15:0] h, input logic [7:0] n, input int nrec, input logic [7:0] code);
        logic [7:0] b [$];
        b = {h[7:0], h[15:8], n};
        for (int i = 0; i < nrec; i++) b = {b, rq_op[i], rq_ev[i]};
        resp_q.push_back(code);
        if (code == RC_SUCCESS) begin
            for (int i = 0; i < n; i++) begin
                if (rq_op[i] == OP_DISABLED && exp_op[i] != 2'd2 && dmask[i]) exp_val[i] = dval[i];
                exp_op[i] = rq_op[i][1:0];
                if (rq_ev[i] != EV_KEEP) exp_ev[i] = (rq_ev[i] == EV_ON);
            end
        end
        u_host.send(b, $unsigned($random(seed)) % 3);
    endtask
    task automatic set_try(input logic [2:0] i, input logic [7:0] v);
        set_q.push_back({exp_op[i] != 2'd1, 8'(exp_op[i] == 2'd1 && exp_ev[i] && exp_val[i] != v) << i});
        if (exp_op[i] == 2'd1) exp_val[i] = v;
        @(posedge clk);
        set_valid <= 1'b1;
        set_index <= i;
        set_value <= v;
        @(posedge clk);
        set_valid <= 1'b0;
        set_value <= ~v;
        repeat (2) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (nrst && resp_valid && resp_ready) check({24'h0, resp_code}, {24'h0, resp_q.pop_front()});
        if (nrst && (set_refused || set_accepted))
            check({23'h0, set_refused, event_pulse}, {23'h0, set_q.pop_front()});
    end
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
    initial begin
        int n;
        {nrst, avs_read, avs_write, set_valid, set_index, set_value, avs_address, avs_writedata} = '0;
        rq_op = {8{OP_ENABLED}};
        rq_ev = {8{EV_KEEP}};
        {exp_val, dval, dmask, exp_ev} = '0;
        exp_op = {8{2'd1}};
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_chk(REG_HANDLE, 32'h0001);
        check_members();
        rd_chk(REG_IRQ_CLR, 32'h0);
        rd_chk(6'h3c, 32'h0);
        wr(REG_DEF_MASK, 32'h01);
        wr(REG_DEF_LO, 32'h5a);
        dmask = 8'h01;
        dval[0] = 8'h5a;
        set_try(3'd0, 8'h33);
        rq_op[0] = OP_DISABLED;
        rq_ev[0] = EV_ON;
        req(16'h0001, 8'h01, 1, RC_SUCCESS);
        set_try(3'd0, 8'h44);
        check_members();
        wr(REG_HANDLE, 32'hffff);
        req(16'hffff, 8'h01, 1, RC_BAD_HANDLE);
        wr(REG_HANDLE, 32'h0);
        req(16'h0000, 8'h01, 1, RC_BAD_HANDLE);
        own = $random(seed);
        if (own == 16'h0000 || own == 16'hffff) own = 16'h2b4d;
        wr(REG_HANDLE, {16'h0, own});
        req(own ^ 16'h0100, 8'h01, 1, RC_BAD_HANDLE);
        req(own, 8'h00, 0, RC_BAD_DATA);
        req(own, 8'h09, 1, RC_BAD_DATA);
        req(own, 8'h02, 1, RC_BAD_LEN);
        req(own, 8'h01, 2, RC_BAD_LEN);
        rq_op[0] = 8'h04;
        req(own, 8'h01, 1, RC_BAD_DATA);
        rq_op[0] = 8'h00;
        req(own, 8'h01, 1, RC_BAD_DATA);
        rq_op[0] = OP_ENABLED;
        rq_ev[0] = 8'h02;
        req(own, 8'h01, 1, RC_BAD_DATA);
        check_members();
        repeat (8) begin
            for (int i = 0; i < MEMBERS; i++) begin
                rq_op[i] = 8'($unsigned($random(seed)) % 3) + 8'h01;
                n = $unsigned($random(seed)) % 3;
                rq_ev[i] = (n == 2) ? EV_KEEP : 8'(n);
            end
            n = 1 + $unsigned($random(seed)) % 8;
            req(own, 8'(n), n, RC_SUCCESS);
            check_members();
            for (int i = 0; i < MEMBERS; i++) set_try(3'(i), 8'($random(seed)));
            check_members();
        end
        rd_chk(REG_IRQ_ST, 32'hf);
        wr(REG_IRQ_EN, 32'h0);
        check({31'h0, irq}, 32'h0);
        wr(REG_IRQ_EN, 32'h1 << IRQ_HANDLE);
        @(negedge clk);
        check({31'h0, irq}, 32'h1);
        wr(REG_IRQ_CLR, 32'h1 << IRQ_HANDLE);
        @(negedge clk);
        check({31'h0, irq}, 32'h0);
        rd_chk(REG_IRQ_ST, 32'hd);
        rd_chk(REG_IRQ_EN, 32'h2);
        check(resp_q.size() + set_q.size(), 32'h0);
        report_and_stop();
    end
endmodule
bind sse_enable_cmd sse_enable_cmd_assertions u_chk (.clk(clk), .nrst(nrst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .rx_valid(rx_valid), .rx_last(rx_last),
    .rx_ready(rx_ready), .resp_valid(resp_valid), .resp_code(resp_code), .resp_ready(resp_ready),
    .set_valid(set_valid), .set_refused(set_refused), .set_accepted(set_accepted));
`default_nettype wire
